// ==== fras_pkg.sv ====
// Constants and types of the spectral record averaging and storage block
package fras_pkg;
    // Register byte addresses, each register on an even address
    localparam logic [6:0] ADR_X_TRIM = 7'h02;
    localparam logic [6:0] ADR_Y_TRIM = 7'h04;
    localparam logic [6:0] ADR_Z_TRIM = 7'h06;
    localparam logic [6:0] ADR_AVG_LO = 7'h0C;
    localparam logic [6:0] ADR_AVG_HI = 7'h0E;
    localparam logic [6:0] ADR_REC_CTRL = 7'h1A;
    localparam logic [6:0] ADR_GLOBAL_COMMAND = 7'h3E;
    localparam logic [6:0] ADR_FLASH_CNT = 7'h5E;
    localparam logic [6:0] ADR_REC_CNT = 7'h78;
    // Command word layout
    localparam int CMD_WR_BIT = 15;
    localparam int CMD_ADR_LSB = 8;
    // Global command bits
    localparam int GC_RESTORE_BIT = 3;
    localparam int GC_ERASE_BIT = 8;
    // Record control fields
    localparam int RC_MODE_LSB = 0;
    localparam int RC_STORE_LSB = 2;
    localparam int RC_WIN_LSB = 12;
    localparam logic [1:0] MODE_TIME = 2'h2;
    localparam logic [1:0] STORE_ALARM = 2'h1;
    localparam logic [1:0] STORE_ALL = 2'h2;
    localparam logic [1:0] WIN_RECT = 2'h0;
    // Reset values
    localparam logic [15:0] AVG_LO_RST = 16'h0108;
    localparam logic [15:0] AVG_HI_RST = 16'h0101;
    localparam logic [15:0] REC_CTRL_RST = 16'h0000;
    localparam logic [15:0] TRIM_RST = 16'h0000;
    // Record geometry and arithmetic
    localparam logic [8:0] LAST_SAMPLE = 9'h1FF;
    localparam logic [7:0] LAST_BIN = 8'hFF;
    localparam int TRIM_SHIFT = 18;
    localparam int WIN_SHIFT = 15;
    localparam logic signed [17:0] SAT_MAX = 18'sh07FFF;
    localparam logic signed [17:0] SAT_MIN = -18'sh08000;
    localparam logic [3:0] RATE_NIB_MAX = 4'hA;
    localparam logic [4:0] SLOT_TOTAL = 5'h0E;
    localparam logic [4:0] SLOT_SHARE [4] = '{5'h0E, 5'h07, 5'h04, 5'h03};
    // Timing figures in milliseconds and their cycle counts
    localparam real CLK_MHZ = 20.0;
    localparam real PT_MS = 18.7;
    localparam real FFT_MS = 32.7;
    localparam real ST_MS = 120.0;
    localparam real AST_MS = 2.21;
    localparam int PT_CYC = int'($ceil(PT_MS * 1000.0 * CLK_MHZ));
    localparam int FFT_CYC = int'($ceil(FFT_MS * 1000.0 * CLK_MHZ));
    localparam int ST_CYC = int'($ceil(ST_MS * 1000.0 * CLK_MHZ));
    localparam int AST_CYC = int'($ceil(AST_MS * 1000.0 * CLK_MHZ));
    // Three axis word, x in the top bits
    typedef struct packed {
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] z;
    } fras_axes_t;
    // Recording sequencer states
    typedef enum logic [2:0] {S_IDLE, S_SAMPLE, S_PROC, S_XFORM, S_STORE, S_ASCAN} fras_state_t;
endpackage

// ==== fras_core.sv ====
// Spectral record averaging and storage block with its register file
`timescale 1ns/100ps
module fras_core #(
    parameter int PT_CYCLES = fras_pkg::PT_CYC,
    parameter int FFT_CYCLES = fras_pkg::FFT_CYC,
    parameter int ST_CYCLES = fras_pkg::ST_CYC,
    parameter int AST_CYCLES = fras_pkg::AST_CYC
) (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic ARST_N,
    // Host command words and read data
    input wire logic CMD_VALID,
    input wire logic [15:0] CMD_WORD,
    output logic [15:0] RD_DATA,
    // Factory trims held in nonvolatile memory
    input wire fras_pkg::fras_axes_t FACTORY_TRIM,
    // Settings and events of neighbouring blocks
    input wire logic [15:0] RATE_NIBBLES,
    input wire logic [3:0] RATE_ENABLE,
    input wire logic [4:0] ALARM_ENABLES,
    input wire logic ALARM_HIT,
    input wire logic TRIGGER,
    output logic [3:0] RATE_NIBBLE,
    // Time samples and window coefficient
    input wire logic SAMPLE_VALID,
    input wire fras_pkg::fras_axes_t SAMPLE,
    input wire logic [15:0] WIN_COEF,
    output logic [1:0] WIN_SEL,
    output logic [8:0] WIN_INDEX,
    // Transform engine feed and bin return
    output logic TX_VALID,
    output fras_pkg::fras_axes_t TX_DATA,
    input wire logic BIN_VALID,
    input wire fras_pkg::fras_axes_t BIN_MAG,
    // Data buffer write port
    output logic BUF_WE,
    output logic [8:0] BUF_ADDR,
    output fras_pkg::fras_axes_t BUF_DATA,
    // Nonvolatile record control and status
    output logic NV_STORE,
    output logic [3:0] NV_SLOT,
    output logic NV_ERASE,
    output logic BUSY
);
    import fras_pkg::*;

    // Registers of the host map
    logic [15:0] trim_r [3];
    logic [15:0] avg_lo_r, avg_hi_r, rec_ctrl_r, rd_r;
    logic [4:0] rec_cnt_r, opt_cnt_r [4];
    logic [15:0] flash_cnt_r;
    logic restore_pend_r;
    // Sequencer state
    fras_state_t state_r, state_nxt;
    logic [21:0] tmr_r;
    logic [1:0] opt_r, opt_nxt, first_opt, next_opt;
    logic has_next;
    logic [8:0] smp_r;
    logic [7:0] bin_r, avg_idx_r;
    logic bins_done_r;
    // Data path registers
    logic [23:0] acc_r [256][3];
    fras_axes_t tx_data_r, buf_data_r, win_w, trim_w, mean_w;
    logic tx_valid_r, buf_we_r, nv_store_r, nv_erase_r;
    logic [8:0] buf_addr_r;
    logic [3:0] nv_slot_r;

    // Command decode
    wire logic wr = CMD_VALID && CMD_WORD[CMD_WR_BIT];
    wire logic rd = CMD_VALID && !CMD_WORD[CMD_WR_BIT];
    wire logic [6:0] adr = CMD_WORD[CMD_WR_BIT-1:CMD_ADR_LSB];
    wire logic [6:0] adr_even = {adr[6:1], 1'b0};
    wire logic hi = adr[0];
    wire logic [15:0] wdat = {CMD_WORD[7:0], CMD_WORD[7:0]};
    wire logic glob_wr = wr && adr_even == ADR_GLOBAL_COMMAND;
    wire logic erase = glob_wr && hi && wdat[GC_ERASE_BIT];
    wire logic restore = restore_pend_r || (glob_wr && !hi && wdat[GC_RESTORE_BIT]);

    // Byte lane merge of a register write
    function automatic logic [15:0] bwr(input logic [15:0] old, input logic h, input logic [15:0] d);
        bwr = h ? {d[15:8], old[7:0]} : {old[15:8], d[7:0]};
    endfunction

    // Settings taken from the registers and the neighbouring blocks
    wire logic [1:0] rec_mode = rec_ctrl_r[RC_MODE_LSB +: 2];
    wire logic [1:0] store_mode = rec_ctrl_r[RC_STORE_LSB +: 2];
    wire logic time_mode = rec_mode == MODE_TIME;
    wire logic [31:0] avg_all = {avg_hi_r, avg_lo_r};
    wire logic [7:0] avg_byte = avg_all[8*opt_r +: 8];
    // A zero byte is taken as one result
    wire logic [7:0] avg_n = (time_mode || avg_byte == 8'h00) ? 8'h01 : avg_byte;
    wire logic last_avg = avg_idx_r == avg_n - 8'h01;
    wire logic first_avg = avg_idx_r == 8'h00;
    wire logic [3:0] nib_raw = RATE_NIBBLES[4*opt_r +: 4];
    wire logic [2:0] sel_cnt = 3'(RATE_ENABLE[0]) + 3'(RATE_ENABLE[1]) + 3'(RATE_ENABLE[2]) + 3'(RATE_ENABLE[3]);
    wire logic [4:0] share = SLOT_SHARE[sel_cnt == 3'h0 ? 2'h0 : 2'(sel_cnt - 3'h1)];
    wire logic room = rec_cnt_r < SLOT_TOTAL && opt_cnt_r[opt_r] < share;
    wire logic store_sel = store_mode == STORE_ALARM || store_mode == STORE_ALL;
    wire logic do_store = store_mode == STORE_ALL || (store_mode == STORE_ALARM && ALARM_HIT);
    wire logic scan_sel = |ALARM_ENABLES;
    wire logic enter_store = state_r != S_STORE && state_nxt == S_STORE;
    wire logic nv_store = enter_store && do_store && room;

    // First enabled option and the next one after the current
    always_comb begin
        first_opt = 2'h0;
        next_opt = 2'h0;
        has_next = 1'b0;
        for (int k = 3; k >= 0; k--) begin
            if (RATE_ENABLE[k]) begin
                first_opt = 2'(k);
            end
            if (RATE_ENABLE[k] && k > int'(opt_r)) begin
                next_opt = 2'(k);
                has_next = 1'b1;
            end
        end
    end

    // Sequencer over samples, processing, transform, storage and scan
    always_comb begin
        state_nxt = state_r;
        opt_nxt = opt_r;
        case (state_r)
            S_IDLE: begin
                if (TRIGGER && |RATE_ENABLE) begin
                    state_nxt = S_SAMPLE;
                    opt_nxt = first_opt;
                end
            end
            S_SAMPLE: begin
                if (SAMPLE_VALID && smp_r == LAST_SAMPLE) begin
                    state_nxt = S_PROC;
                end
            end
            S_PROC: begin
                if (tmr_r >= 22'(PT_CYCLES - 1)) begin
                    if (!time_mode) begin
                        state_nxt = S_XFORM;
                    end else if (store_sel) begin
                        state_nxt = S_STORE;
                    end else if (scan_sel) begin
                        state_nxt = S_ASCAN;
                    end else begin
                        state_nxt = has_next ? S_SAMPLE : S_IDLE;
                        opt_nxt = has_next ? next_opt : opt_r;
                    end
                end
            end
            S_XFORM: begin
                if (bins_done_r && tmr_r >= 22'(FFT_CYCLES - 1)) begin
                    if (!last_avg) begin
                        state_nxt = S_SAMPLE;
                    end else if (store_sel) begin
                        state_nxt = S_STORE;
                    end else if (scan_sel) begin
                        state_nxt = S_ASCAN;
                    end else begin
                        state_nxt = has_next ? S_SAMPLE : S_IDLE;
                        opt_nxt = has_next ? next_opt : opt_r;
                    end
                end
            end
            S_STORE: begin
                if (tmr_r >= 22'(ST_CYCLES - 1)) begin
                    if (scan_sel) begin
                        state_nxt = S_ASCAN;
                    end else begin
                        state_nxt = has_next ? S_SAMPLE : S_IDLE;
                        opt_nxt = has_next ? next_opt : opt_r;
                    end
                end
            end
            S_ASCAN: begin
                if (tmr_r >= 22'(AST_CYCLES - 1)) begin
                    state_nxt = has_next ? S_SAMPLE : S_IDLE;
                    opt_nxt = has_next ? next_opt : opt_r;
                end
            end
            default: begin
                state_nxt = S_IDLE;
            end
        endcase
    end

    // State, timer, option and averaging pass
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_r <= S_IDLE;
            tmr_r <= 22'h000000;
            opt_r <= 2'h0;
            avg_idx_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            opt_r <= opt_nxt;
            tmr_r <= (state_nxt != state_r) ? 22'h000000 : tmr_r + 22'h000001;
            // Next pass of the same record, or a fresh record
            if (state_r == S_XFORM && state_nxt == S_SAMPLE && !last_avg) begin
                avg_idx_r <= avg_idx_r + 8'h01;
            end else if (state_r != S_XFORM && state_r != S_SAMPLE && state_nxt == S_SAMPLE) begin
                avg_idx_r <= 8'h00;
            end
        end
    end

    // Sample and bin counters
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            smp_r <= 9'h000;
            bin_r <= 8'h00;
            bins_done_r <= 1'b0;
        end else begin
            smp_r <= (state_r == S_SAMPLE && SAMPLE_VALID) ? smp_r + 9'h001 : (state_r == S_SAMPLE ? smp_r : 9'h000);
            bin_r <= (state_r == S_XFORM && BIN_VALID) ? bin_r + 8'h01 : (state_r == S_XFORM ? bin_r : 8'h00);
            bins_done_r <= state_r == S_XFORM && (bins_done_r || (BIN_VALID && bin_r == LAST_BIN));
        end
    end

    // Per axis trim, window and averaging arithmetic
    for (genvar i = 0; i < 3; i++) begin : g_axis
        wire logic signed [15:0] smp = SAMPLE[16*i +: 16];
        wire logic signed [15:0] scf = trim_r[2-i];
        wire logic signed [31:0] prod = smp * scf;
        wire logic signed [17:0] corr = 18'(smp) + 18'(prod >>> TRIM_SHIFT);
        // Clamp to sixteen-bit full scale
        wire logic signed [17:0] sat = corr > SAT_MAX ? SAT_MAX : (corr < SAT_MIN ? SAT_MIN : corr);
        wire logic signed [33:0] wprod = 34'(sat) * 34'($signed({1'b0, WIN_COEF}));
        assign trim_w[16*i +: 16] = 16'(sat);
        assign win_w[16*i +: 16] = (WIN_SEL == WIN_RECT) ? 16'(sat) : 16'(wprod >>> WIN_SHIFT);
        // Sum restarts on the first pass of a record
        wire logic [23:0] sum = (first_avg ? 24'h000000 : acc_r[bin_r][i]) + 24'(BIN_MAG[16*i +: 16]);
        assign mean_w[16*i +: 16] = 16'(sum / 24'(avg_n));
        always_ff @(posedge CLOCK) begin
            if (state_r == S_XFORM && BIN_VALID && !bins_done_r) begin
                acc_r[bin_r][i] <= sum;
            end
        end
    end

    // Transform feed and data buffer writes
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            tx_valid_r <= 1'b0;
            tx_data_r <= '0;
            buf_we_r <= 1'b0;
            buf_addr_r <= 9'h000;
            buf_data_r <= '0;
        end else begin
            tx_valid_r <= state_r == S_SAMPLE && SAMPLE_VALID && !time_mode;
            tx_data_r <= win_w;
            // Time records go straight in, spectra on the last pass only
            buf_we_r <= (state_r == S_SAMPLE && SAMPLE_VALID && time_mode)
                || (state_r == S_XFORM && BIN_VALID && !bins_done_r && last_avg);
            buf_addr_r <= time_mode ? smp_r : {1'b0, bin_r};
            buf_data_r <= time_mode ? trim_w : mean_w;
        end
    end

    // Host registers, restore and read data
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            trim_r <= '{TRIM_RST, TRIM_RST, TRIM_RST};
            avg_lo_r <= AVG_LO_RST;
            avg_hi_r <= AVG_HI_RST;
            rec_ctrl_r <= REC_CTRL_RST;
            restore_pend_r <= 1'b1;
            rd_r <= 16'h0000;
        end else begin
            restore_pend_r <= 1'b0;
            if (restore) begin
                trim_r <= '{FACTORY_TRIM.x, FACTORY_TRIM.y, FACTORY_TRIM.z};
            end else if (wr && adr_even == ADR_X_TRIM) begin
                trim_r[0] <= bwr(trim_r[0], hi, wdat);
            end else if (wr && adr_even == ADR_Y_TRIM) begin
                trim_r[1] <= bwr(trim_r[1], hi, wdat);
            end else if (wr && adr_even == ADR_Z_TRIM) begin
                trim_r[2] <= bwr(trim_r[2], hi, wdat);
            end
            if (wr && adr_even == ADR_AVG_LO) begin
                avg_lo_r <= bwr(avg_lo_r, hi, wdat);
            end
            if (wr && adr_even == ADR_AVG_HI) begin
                avg_hi_r <= bwr(avg_hi_r, hi, wdat);
            end
            if (wr && adr_even == ADR_REC_CTRL) begin
                rec_ctrl_r <= bwr(rec_ctrl_r, hi, wdat);
            end
            if (rd) begin
                case (adr_even)
                    ADR_X_TRIM: rd_r <= trim_r[0];
                    ADR_Y_TRIM: rd_r <= trim_r[1];
                    ADR_Z_TRIM: rd_r <= trim_r[2];
                    ADR_AVG_LO: rd_r <= avg_lo_r;
                    ADR_AVG_HI: rd_r <= avg_hi_r;
                    ADR_REC_CTRL: rd_r <= rec_ctrl_r;
                    ADR_FLASH_CNT: rd_r <= flash_cnt_r;
                    ADR_REC_CNT: rd_r <= {11'h000, rec_cnt_r};
                    default: rd_r <= 16'h0000;
                endcase
            end
        end
    end

    // Record counters; a store in the erase cycle still counts
    for (genvar o = 0; o < 4; o++) begin : g_opt
        always_ff @(posedge CLOCK or negedge ARST_N) begin
            if (!ARST_N) begin
                opt_cnt_r[o] <= 5'h00;
            end else begin
                opt_cnt_r[o] <= (erase ? 5'h00 : opt_cnt_r[o]) + 5'((nv_store && opt_r == 2'(o)));
            end
        end
    end
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            rec_cnt_r <= 5'h00;
            flash_cnt_r <= 16'h0000;
            nv_store_r <= 1'b0;
            nv_erase_r <= 1'b0;
            nv_slot_r <= 4'h0;
        end else begin
            rec_cnt_r <= (erase ? 5'h00 : rec_cnt_r) + 5'(nv_store);
            if (nv_store && !erase && rec_cnt_r == SLOT_TOTAL - 5'h01) begin
                flash_cnt_r <= flash_cnt_r + 16'h0001;
            end
            nv_store_r <= nv_store;
            nv_erase_r <= erase;
            nv_slot_r <= erase ? 4'h0 : rec_cnt_r[3:0];
        end
    end

    // Outputs
    assign RD_DATA = rd_r;
    assign RATE_NIBBLE = nib_raw > RATE_NIB_MAX ? RATE_NIB_MAX : nib_raw;
    assign WIN_SEL = rec_ctrl_r[RC_WIN_LSB +: 2];
    assign WIN_INDEX = smp_r;
    assign TX_VALID = tx_valid_r;
    assign TX_DATA = tx_data_r;
    assign BUF_WE = buf_we_r;
    assign BUF_ADDR = buf_addr_r;
    assign BUF_DATA = buf_data_r;
    assign NV_STORE = nv_store_r;
    assign NV_SLOT = nv_slot_r;
    assign NV_ERASE = nv_erase_r;
    assign BUSY = state_r != S_IDLE;

    // Checks
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!ARST_N);
    sequence s_store_req;
        nv_store && !erase;
    endsequence
    property p_rec_cap;
        rec_cnt_r <= SLOT_TOTAL;
    endproperty
    a_rec_cap: assert property (p_rec_cap) else $error("record count above fourteen");
    property p_cnt_inc;
        s_store_req |=> rec_cnt_r == $past(rec_cnt_r) + 5'h01 ##1 NV_STORE == 1'b0 || rec_cnt_r != 5'h00;
    endproperty
    a_cnt_inc: assert property (p_cnt_inc) else $error("record count did not step");
    property p_erase;
        erase && !nv_store |=> rec_cnt_r == 5'h00 && NV_ERASE;
    endproperty
    a_erase: assert property (p_erase) else $error("erase left records");
    property p_flash;
        s_store_req and rec_cnt_r == SLOT_TOTAL - 5'h01 |=> flash_cnt_r == $past(flash_cnt_r) + 16'h0001;
    endproperty
    a_flash: assert property (p_flash) else $error("flash cycle count missed");
    property p_share;
        nv_store |-> opt_cnt_r[opt_r] < share ##1 NV_STORE;
    endproperty
    a_share: assert property (p_share) else $error("option share exceeded");
    property p_restore;
        glob_wr && !hi && wdat[GC_RESTORE_BIT] |=> trim_r[0] == $past(FACTORY_TRIM.x) && trim_r[2] == $past(FACTORY_TRIM.z);
    endproperty
    a_restore: assert property (p_restore) else $error("factory trims not restored");
    property p_store_sel;
        enter_store |-> store_sel ##1 state_r == S_STORE;
    endproperty
    a_store_sel: assert property (p_store_sel) else $error("storage time without storage");
    property p_buf_last;
        BUF_WE && !time_mode |-> $past(last_avg) && $past(state_r) == S_XFORM;
    endproperty
    a_buf_last: assert property (p_buf_last) else $error("buffer written before last pass");
endmodule

// ==== fras_host_model.sv ====
// Host model that sends register command words and captures read data
`timescale 1ns/100ps
module fras_host_model (
    // Clock
    input wire logic clk,
    // Command words and answers
    output logic cmd_valid,
    output logic [15:0] cmd_word,
    input wire logic [15:0] rd_data
);
    // Quiet port before the first word
    initial begin
        cmd_valid = 1'b0;
        cmd_word = 16'h0000;
    end
    // One word, then a quiet edge; no recording period is ever set
    task automatic send(input logic [15:0] w, output logic [15:0] rd);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_word <= w;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_word <= ~w;
        // Read data stands from the edge that took the word; take it one edge later
        @(posedge clk);
        rd = rd_data;
    endtask
endmodule

// ==== fras_core_test.sv ====
// Self-checking bench for the spectral record averaging and storage block
`timescale 1ns/100ps
module fras_core_test;
    import fras_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic cmd_valid, trigger = 1'b0, sv = 1'b0, bv = 1'b0;
    // Neighbour settings driven by the bench
    logic [15:0] rate_nib = 16'h00F3;
    logic [3:0] rate_en = 4'h2, rate_nibble, nv_slot;
    logic [4:0] alm_en = 5'h00;
    logic alm_hit = 1'b0, tmode = 1'b0;
    logic [8:0] win_index;
    // Constant samples after the restored gain trims, x on top
    localparam logic [47:0] TRIMMED = {16'h0104, 16'h0211, 16'h0326};
    logic tx_valid, buf_we, nv_store, nv_erase, busy;
    logic [15:0] cmd_word, rd_data, v;
    logic [1:0] win_sel;
    logic [8:0] buf_addr;
    fras_axes_t buf_data, tx_data, bin_mag = '0;
    int miscompares = 0, checks_done = 0, tx_cnt = 0, wr_cnt = 0, st_cnt = 0, er_cnt = 0, i, p;
    int slot_exp = 0;
    // Clock at 50 ns
    always #25 clk = ~clk;
    fras_host_model host_u (.clk(clk), .cmd_valid(cmd_valid), .cmd_word(cmd_word), .rd_data(rd_data));
    fras_core #(.PT_CYCLES(4), .FFT_CYCLES(8), .ST_CYCLES(6), .AST_CYCLES(3)) dut_u (
        .CLOCK(clk), .ARST_N(arst_n), .CMD_VALID(cmd_valid), .CMD_WORD(cmd_word), .RD_DATA(rd_data),
        .FACTORY_TRIM({16'h1111, 16'h2222, 16'h3333}), .RATE_NIBBLES(rate_nib), .RATE_ENABLE(rate_en),
        .ALARM_ENABLES(alm_en), .ALARM_HIT(alm_hit), .TRIGGER(trigger), .RATE_NIBBLE(rate_nibble),
        .SAMPLE_VALID(sv), .SAMPLE({16'h0100, 16'h0200, 16'h0300}), .WIN_COEF(16'h8000),
        .WIN_SEL(win_sel), .WIN_INDEX(win_index), .TX_VALID(tx_valid), .TX_DATA(tx_data), .BIN_VALID(bv),
        .BIN_MAG(bin_mag), .BUF_WE(buf_we), .BUF_ADDR(buf_addr), .BUF_DATA(buf_data),
        .NV_STORE(nv_store), .NV_SLOT(nv_slot), .NV_ERASE(nv_erase), .BUSY(busy));
    // Compare and count
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    // Read one register and compare
    task automatic rd_chk(input logic [15:0] w, input logic [15:0] exp);
        host_u.send(w, v);
        check(48'(v), 48'(exp));
    endtask
    // Pulse counters, slot order and data; spectra hold at bin k the mean of its two pass values 2k and 2k+2
    always @(posedge clk) begin
        if (tx_valid) begin
            tx_cnt++;
            check(tx_data, TRIMMED);
        end
        if (nv_erase) begin
            er_cnt++;
            slot_exp = 0;
        end
        if (nv_store) begin
            check(48'(nv_slot), 48'(slot_exp));
            slot_exp++;
            st_cnt++;
        end
        if (buf_we) begin
            wr_cnt++;
            check(buf_data, tmode ? TRIMMED : {3{6'h00, buf_addr, 1'b1}});
        end
    end
    // Optional start pulse, then 512 strobed samples against the window index
    task automatic run_samples(input logic start);
        if (start) begin
            @(posedge clk) trigger <= 1'b1;
            @(posedge clk) trigger <= 1'b0;
        end
        for (i = 0; i < 512; i++) begin
            @(posedge clk) begin
                check(48'(win_index), 48'(i));
                sv <= 1'b1;
            end
            @(posedge clk) sv <= 1'b0;
        end
    endtask
    // Bounded wait for the sequencer to go idle
    task automatic wait_idle();
        for (i = 0; i < 300 && busy !== 1'b0; i++) @(posedge clk);
        check(48'(busy), 48'd0);
    endtask
    // Reset values, read-only and unmapped places
    task automatic reg_defaults();
        rd_chk(16'h0C00, 16'h0108);
        rd_chk(16'h0E00, 16'h0101);
        check(48'(rate_nibble), 48'd3);
        host_u.send(16'hF805, v);
        rd_chk(16'h7800, 16'h0000);
        rd_chk(16'h5E00, 16'h0000);
        rd_chk(16'h1000, 16'h0000);
    endtask
    // Host overwrite of a trim, then factory restore
    task automatic trim_restore();
        rd_chk(16'h0200, 16'h1111);
        host_u.send(16'h82CD, v);
        host_u.send(16'h83AB, v);
        rd_chk(16'h0200, 16'hABCD);
        host_u.send(16'hBE08, v);
        rd_chk(16'h0200, 16'h1111);
        rd_chk(16'h0400, 16'h2222);
        rd_chk(16'h0600, 16'h3333);
    endtask
    // Byte write to the option 1 averaging count
    task automatic avg_write();
        host_u.send(16'h8D0B, v);
        rd_chk(16'h0C00, 16'h0B08);
    endtask
    // Window codes 0 to 2 reach the window select
    task automatic window_sel();
        for (i = 0; i < 3; i++) begin
            host_u.send(16'h9B00 | 16'(i << 4), v);
            check(48'(win_sel), 48'(i));
        end
    endtask
    // Two averaged passes, storage of every set, then erase
    task automatic record_store_erase();
        host_u.send(16'h8D02, v);
        host_u.send(16'h9A08, v);
        for (p = 0; p < 2; p++) begin
            tx_cnt = 0;
            run_samples(p == 0);
            repeat (20) @(posedge clk);
            check(48'(tx_cnt), 48'd512);
            for (i = 0; i < 256; i++) begin
                @(posedge clk) begin
                    bv <= 1'b1;
                    bin_mag <= {3{16'(2 * i + 2 * p)}};
                end
                @(posedge clk) bv <= 1'b0;
            end
        end
        wait_idle();
        check(48'(wr_cnt), 48'd256);
        check(48'(st_cnt), 48'd1);
        check(48'(rate_nibble), 48'd10);
        rd_chk(16'h7800, 16'h0001);
        host_u.send(16'hBF01, v);
        @(posedge clk);
        check(48'(er_cnt), 48'd1);
        rd_chk(16'h7800, 16'h0000);
    endtask
    // Time mode record, alarm-only storage with no alarm, scan enabled
    task automatic time_record();
        alm_en <= 5'h01;
        tmode = 1'b1;
        host_u.send(16'h9A06, v);
        wr_cnt = 0;
        tx_cnt = 0;
        run_samples(1'b1);
        wait_idle();
        check(48'(wr_cnt), 48'd512);
        check(48'(tx_cnt), 48'd0);
        check(48'(st_cnt), 48'd1);
    endtask
    // Alarm stores until all slots are taken, then one record more
    task automatic slot_fill();
        alm_hit <= 1'b1;
        for (p = 0; p < 15; p++) begin
            run_samples(1'b1);
            wait_idle();
        end
        check(48'(st_cnt), 48'd15);
        rd_chk(16'h7800, 16'h000E);
        rd_chk(16'h5E00, 16'h0001);
    endtask
    // Counts and verdict
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Hang guard well beyond the expected run
    initial begin
        repeat (40000) @(posedge clk);
        miscompares++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        reg_defaults();
        trim_restore();
        avg_write();
        window_sel();
        record_store_erase();
        time_record();
        slot_fill();
        report_and_stop();
    end
endmodule
